// ### rpsf_bank.sv
`timescale 1ns/1ps
// Purpose: Peer status flag bank for a redundant CPU pair
// Assumes: Peer inputs are stable when end_of_scan_i pulses
// Notes:   Cancel request is edge triggered on the software flag
// Behaviour
// - Flags valid in backup; standalone reads zero
// - Summary flag set when detail word nonzero
// - Copy peer diagnostic error each scan end
// - Copy peer self-diagnostic error each scan end
// - Copy peer common info flag each scan end
// - Copy peer individual info flag each scan
// - Load code, raise request, standby clears error
module rpsf_bank
    import rpsf_pkg::*;
#(
    parameter int unsigned DW = rpsf_pkg::DETAIL_W,
    parameter int unsigned CW = rpsf_pkg::CODE_W
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    // Scan engine and mode
    input  wire logic                  end_of_scan_i,
    input  wire rpsf_pkg::rpsf_mode_e  mode_i,
    // Partner state across tracking link
    input  wire logic [DW-1:0]         peer_error_detail_word_i,
    input  wire logic                  local_diag_error_flag_i,
    input  wire logic                  local_selfdiag_error_flag_i,
    input  wire logic                  local_common_info_flag_i,
    input  wire logic                  local_individual_info_flag_i,
    // Software cancel request
    input  wire logic                  standby_cancel_request_flag_i,
    input  wire logic [CW-1:0]         standby_cancel_code_word_i,
    // Peer status flags
    output logic                       peer_flags_valid_o,
    output logic                       peer_error_summary_flag_o,
    output logic                       peer_diag_error_flag_o,
    output logic                       peer_selfdiag_error_flag_o,
    output logic                       peer_common_info_flag_o,
    output logic                       peer_individual_info_flag_o,
    // Clear command toward standby system
    output logic                       standby_clear_pulse_o,
    output logic [CW-1:0]              standby_clear_code_o
);
    import rpsf_pkg::*;

    logic          valid_r, valid_nxt;
    logic          sum_r, sum_nxt;
    logic          diag_r, diag_nxt;
    logic          sdiag_r, sdiag_nxt;
    logic          comm_r, comm_nxt;
    logic          indiv_r, indiv_nxt;
    logic          clr_r, clr_nxt;
    logic [CW-1:0] code_r, code_nxt;
    logic          req_rise;

    // Edge detector on the software request
    rpsf_rise u_req_rise (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .level_i (standby_cancel_request_flag_i),
        .pulse_o (req_rise)
    );

    // Next values of the flag bank
    always_comb begin
        valid_nxt = (mode_i == RPSF_BACKUP);
        sum_nxt   = sum_r;
        diag_nxt  = diag_r;
        sdiag_nxt = sdiag_r;
        comm_nxt  = comm_r;
        indiv_nxt = indiv_r;
        if (mode_i == RPSF_STANDALONE) begin
            sum_nxt   = FLAG_RST;
            diag_nxt  = FLAG_RST;
            sdiag_nxt = FLAG_RST;
            comm_nxt  = FLAG_RST;
            indiv_nxt = FLAG_RST;
        end else if (end_of_scan_i) begin
            sum_nxt   = |peer_error_detail_word_i;
            diag_nxt  = local_diag_error_flag_i;
            sdiag_nxt = local_selfdiag_error_flag_i;
            comm_nxt  = local_common_info_flag_i;
            indiv_nxt = local_individual_info_flag_i;
        end
    end

    // Next values of the clear command
    always_comb begin
        clr_nxt  = 1'b0;
        code_nxt = code_r;
        if (req_rise && mode_i != RPSF_STANDALONE) begin
            clr_nxt  = 1'b1;
            code_nxt = standby_cancel_code_word_i;
        end
    end

    // Register everything
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            valid_r <= FLAG_RST;
            sum_r   <= FLAG_RST;
            diag_r  <= FLAG_RST;
            sdiag_r <= FLAG_RST;
            comm_r  <= FLAG_RST;
            indiv_r <= FLAG_RST;
            clr_r   <= FLAG_RST;
            code_r  <= CW'(WORD_RST);
        end else begin
            valid_r <= valid_nxt;
            sum_r   <= sum_nxt;
            diag_r  <= diag_nxt;
            sdiag_r <= sdiag_nxt;
            comm_r  <= comm_nxt;
            indiv_r <= indiv_nxt;
            clr_r   <= clr_nxt;
            code_r  <= code_nxt;
        end
    end

    assign peer_flags_valid_o          = valid_r;
    assign peer_error_summary_flag_o   = sum_r;
    assign peer_diag_error_flag_o      = diag_r;
    assign peer_selfdiag_error_flag_o  = sdiag_r;
    assign peer_common_info_flag_o     = comm_r;
    assign peer_individual_info_flag_o = indiv_r;
    assign standby_clear_pulse_o       = clr_r;
    assign standby_clear_code_o        = code_r;

    // Reset clears every output, so no stale peer state survives it
    AST_RESET_ZERO: assert property (
        @(posedge clk_i)
        !nrst_i |=> !valid_r && !sum_r && !diag_r && !sdiag_r && !comm_r
            && !indiv_r && !clr_r && code_r == CW'(WORD_RST))
        else $error("outputs not cleared by reset");

    // Mode handling
    AST_STANDALONE_ZERO: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        mode_i == RPSF_STANDALONE |=> !sum_r && !diag_r && !sdiag_r
            && !comm_r && !indiv_r)
        else $error("flags not zero in standalone");
    AST_VALID_BACKUP: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        1'b1 |=> valid_r == ($past(mode_i) == RPSF_BACKUP))
        else $error("valid flag wrong");
    AST_STANDALONE_NO_CLEAR: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        mode_i == RPSF_STANDALONE |=> !clr_r)
        else $error("clear issued in standalone");

    // Scan-end copies of the partner state
    AST_SUMMARY: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        end_of_scan_i && mode_i != RPSF_STANDALONE
        |=> sum_r == (|$past(peer_error_detail_word_i)))
        else $error("summary flag wrong");
    AST_DIAG: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        end_of_scan_i && mode_i != RPSF_STANDALONE
        |=> diag_r == $past(local_diag_error_flag_i))
        else $error("diag copy wrong");
    AST_SDIAG: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        end_of_scan_i && mode_i != RPSF_STANDALONE
        |=> sdiag_r == $past(local_selfdiag_error_flag_i))
        else $error("selfdiag copy wrong");
    AST_COMM: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        end_of_scan_i && mode_i != RPSF_STANDALONE
        |=> comm_r == $past(local_common_info_flag_i))
        else $error("common info copy wrong");
    AST_INDIV_COPY: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        end_of_scan_i && mode_i != RPSF_STANDALONE
        |=> indiv_r == $past(local_individual_info_flag_i))
        else $error("individual info copy wrong");

    // Flags hold between scan ends outside standalone mode
    AST_SUM_HOLD: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !end_of_scan_i && mode_i != RPSF_STANDALONE |=> $stable(sum_r))
        else $error("summary flag moved off scan end");
    AST_DIAG_HOLD: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !end_of_scan_i && mode_i != RPSF_STANDALONE |=> $stable(diag_r))
        else $error("diag flag moved off scan end");
    AST_SDIAG_HOLD: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !end_of_scan_i && mode_i != RPSF_STANDALONE |=> $stable(sdiag_r))
        else $error("selfdiag flag moved off scan end");
    AST_COMM_HOLD: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !end_of_scan_i && mode_i != RPSF_STANDALONE |=> $stable(comm_r))
        else $error("common info flag moved off scan end");
    AST_INDIV: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !end_of_scan_i && mode_i != RPSF_STANDALONE
        |=> $stable(indiv_r))
        else $error("individual flag moved off scan end");

    // Cancel request toward the standby system
    AST_CLEAR_CODE: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(standby_cancel_request_flag_i) && mode_i != RPSF_STANDALONE
        ##1 mode_i != RPSF_STANDALONE
        |=> clr_r && code_r == $past(standby_cancel_code_word_i))
        else $error("cancel not issued with code");
    AST_CODE_WITH_PULSE: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        clr_r |-> code_r == $past(standby_cancel_code_word_i))
        else $error("clear code not the requested one");
    AST_CODE_HOLDS: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        1'b1 |=> clr_r || $stable(code_r))
        else $error("clear code moved without a clear");
    AST_NO_REPEAT: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        clr_r |=> !clr_r)
        else $error("repeated clear");
    AST_RISE_ONLY: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        clr_r && $past(nrst_i, 3)
        |-> $past(standby_cancel_request_flag_i, 2)
            && !$past(standby_cancel_request_flag_i, 3))
        else $error("clear without a request edge");
    AST_HELD_NO_CLEAR: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $past(nrst_i, 3) && $past(standby_cancel_request_flag_i, 2)
            && $past(standby_cancel_request_flag_i, 3) |-> !clr_r)
        else $error("held request cleared again");
endmodule // rpsf_bank

// ### rpsf_peer.sv
// Purpose: Partner CPU model presenting its own status over the link
// Assumes: Bench asks for a new state one cycle before each scan end
// Notes:   State only moves on request, so it is stable at scan end
`timescale 1ns/1ps
module rpsf_peer (
    // Clock and new state request
    input  wire logic        clk_i,
    input  wire logic        upd_i,
    input  wire logic [31:0] rnd_i,
    // Partner detail word and own flags
    output logic [15:0]      detail_o,
    output logic [3:0]       flag_o
);
    // Start clean, then load a new diagnostic state when asked
    initial begin
        detail_o = 16'h0000;
        flag_o   = 4'h0;
    end
    always @(posedge clk_i) begin
        if (upd_i) begin
            detail_o <= rnd_i[31:16];
            flag_o   <= rnd_i[3:0];
        end
    end
endmodule // rpsf_peer

// ### rpsf_pkg.sv
// Purpose: Shared constants for the redundant peer status flag bank
// Assumes: 200 MHz clock on clk_i
// Notes:   Mode codes select how the peer flags are treated
package rpsf_pkg;
    // Width of the peer error-detail word
    localparam int unsigned DETAIL_W = 16;
    // Width of the standby cancel code word
    localparam int unsigned CODE_W   = 16;
    // Reset value of every flag
    localparam logic        FLAG_RST = 1'b0;
    // Reset value of the standby cancel code word
    localparam logic [15:0] WORD_RST = 16'h0000;

    // Redundant pair operating modes
    typedef enum logic [1:0] {
        RPSF_STANDALONE = 2'b00,
        RPSF_BACKUP     = 2'b01,
        RPSF_SEPARATE   = 2'b10
    } rpsf_mode_e;
endpackage

// ### rpsf_rise.sv
`timescale 1ns/1ps
// Purpose: Rising-edge detector for a same-clock level
// Assumes: Input is already synchronous to clk_i
// Notes:   Pulse is one cycle wide, registered
module rpsf_rise (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // Level in, pulse out
    input  wire logic level_i,
    output logic      pulse_o
);
    import rpsf_pkg::*;

    logic prev_r;
    logic prev_nxt;
    logic pulse_r;
    logic pulse_nxt;

    // Compare current level with last cycle
    always_comb begin
        prev_nxt  = level_i;
        pulse_nxt = level_i & ~prev_r;
    end

    // Register history and pulse
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            prev_r  <= FLAG_RST;
            pulse_r <= FLAG_RST;
        end else begin
            prev_r  <= prev_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign pulse_o = pulse_r;
endmodule // rpsf_rise

// ### tb_top.sv
// Purpose: Self-checking bench for the peer status flag bank
// Assumes: Inputs change at the falling edge of clk_i
// Notes:   Random peer states come from a fixed-seed shift register
`timescale 1ns/1ps
`define EXPECT(n, e, s) begin checked++; if ((e) !== (s)) begin \
    n_mismatch++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top;
    import rpsf_pkg::*;
    logic        clk_i, nrst_i, eos, req, upd, vld, sum, clr;
    logic [31:0] lfsr, rnd;
    logic [15:0] det, code, ccode, last;
    logic [3:0]  fl, po;
    rpsf_mode_e  mode;
    int          n_mismatch, checked, cyc;
    // Partner and device
    rpsf_peer PEER (.clk_i(clk_i), .upd_i(upd), .rnd_i(rnd),
        .detail_o(det), .flag_o(fl));
    rpsf_bank DUT (.clk_i(clk_i), .nrst_i(nrst_i), .end_of_scan_i(eos),
        .mode_i(mode), .peer_error_detail_word_i(det),
        .local_diag_error_flag_i(fl[3]), .local_selfdiag_error_flag_i(fl[2]),
        .local_common_info_flag_i(fl[1]),
        .local_individual_info_flag_i(fl[0]),
        .standby_cancel_request_flag_i(req),
        .standby_cancel_code_word_i(code), .peer_flags_valid_o(vld),
        .peer_error_summary_flag_o(sum), .peer_diag_error_flag_o(po[3]),
        .peer_selfdiag_error_flag_o(po[2]),
        .peer_common_info_flag_o(po[1]),
        .peer_individual_info_flag_o(po[0]),
        .standby_clear_pulse_o(clr), .standby_clear_code_o(ccode));
    // Next value of the random source
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Verdict and end of run
    task automatic end_of_test;
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // New partner state, one scan end, then compare the copies
    task automatic scan(input logic [31:0] m, input logic [31:0] o);
        logic z;
        z = (mode == RPSF_STANDALONE);
        @(negedge clk_i);
        lfsr = nxt(lfsr);
        rnd = (lfsr & m) | o;
        upd = 1'b1;
        @(negedge clk_i);
        upd = 1'b0;
        eos = 1'b1;
        @(negedge clk_i);
        eos = 1'b0;
        `EXPECT("valid", mode == RPSF_BACKUP, vld)
        `EXPECT("summary", z ? 1'b0 : (|det), sum)
        `EXPECT("flags", z ? 4'h0 : fl, po)
    endtask
    // Load code, raise the request, then hold it high
    task automatic cancel(input logic [15:0] c, input logic e);
        @(negedge clk_i);
        code = c;
        @(negedge clk_i);
        req = 1'b1;
        @(negedge clk_i);
        `EXPECT("early clear", 1'b0, clr)
        @(negedge clk_i);
        `EXPECT("clear pulse", e, clr)
        if (e)
            last = c;
        // New code while held must not be taken
        code = ~c;
        repeat (3) begin
            @(negedge clk_i);
            `EXPECT("held request", 1'b0, clr)
            `EXPECT("clear code", last, ccode)
        end
        req = 1'b0;
    endtask
    // Free-running clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // Main sequence
    initial begin
        {nrst_i, eos, req, upd} = 4'h0;
        mode = RPSF_BACKUP;
        lfsr = 32'h0927_69fb;
        rnd = 32'h0000_0000;
        code = 16'h0000;
        last = 16'h0000;
        repeat (3) @(negedge clk_i);
        nrst_i = 1'b1;
        `EXPECT("reset", 7'h00, {vld, sum, po, clr})
        `EXPECT("reset code", 16'h0000, ccode)
        scan(32'h0000_000f, 32'h0000_0000);
        scan(32'h0000_0000, 32'h8000_0000);
        scan(32'h0000_0000, 32'h0001_0000);
        repeat (20) scan(32'hffff_ffff, 32'h0000_0000);
        cancel(lfsr[31:16], 1'b1);
        cancel(16'hffff, 1'b1);
        // Reset in mid-run with flags and code loaded
        @(negedge clk_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        `EXPECT("mid reset", 7'h00, {vld, sum, po, clr})
        `EXPECT("mid reset code", 16'h0000, ccode)
        nrst_i = 1'b1;
        last = 16'h0000;
        scan(32'hffff_ffff, 32'h0000_000f);
        mode = RPSF_SEPARATE;
        repeat (6) scan(32'hffff_ffff, 32'h0000_0000);
        cancel(lfsr[15:0], 1'b1);
        mode = RPSF_STANDALONE;
        repeat (6) scan(32'hffff_ffff, 32'h0001_000f);
        cancel(lfsr[31:16], 1'b0);
        // Unused mode code behaves like separate mode
        mode = rpsf_mode_e'(2'b11);
        repeat (2) scan(32'hffff_ffff, 32'h0000_0000);
        cancel(lfsr[15:0], 1'b1);
        mode = RPSF_BACKUP;
        repeat (4) scan(32'hffff_ffff, 32'h0000_0000);
        end_of_test();
    end
endmodule // tb_top
